/* File: design/apt_bridge.sv */
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
// ordering and window translation core
module apt_bridge (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  // avalon-mm register slave, word addressed
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // outbound axi request
  input  wire logic                 ob_valid_i,
  output logic                      ob_ready_o,
  input  wire apt_pkg::apt_ob_req_t ob_req_i,
  // outbound response: one-cycle pulse
  output logic                      ob_resp_valid_o,
  output logic                      ob_resp_err_o,
  output logic                      ob_resp_write_o,
  // transmit header toward the link
  output logic                      tx_valid_o,
  input  wire logic                 tx_ready_i,
  output apt_pkg::apt_tlp_t         tx_tlp_o,
  // inbound request from the link
  input  wire logic                 ib_valid_i,
  output logic                      ib_ready_o,
  input  wire apt_pkg::apt_ib_req_t ib_req_i,
  output logic                      ib_err_o,
  // inbound axi request to the fabric
  output logic                      axi_valid_o,
  input  wire logic                 axi_ready_i,
  output apt_pkg::apt_axi_req_t     axi_req_o,
  input  wire logic                 axi_bresp_i,
  // completion data from the link to the axi read channel
  input  wire logic                 cpl_valid_i,
  output logic                      cpl_ready_o,
  input  wire logic [63:0]          cpl_data_i,
  output logic                      rd_valid_o,
  input  wire logic                 rd_ready_i,
  output logic [63:0]               rd_data_o
);
  import apt_pkg::*;

  // outbound window translation: offset from low bound, kept below size
  function automatic logic [PCIE_AW-1:0] ob_xlate(input logic [AXI_AW-1:0] a,
      input logic [AXI_AW-1:0] lo, input logic [AXI_AW-1:0] top,
      input logic [PCIE_AW-1:0] tr);
    logic [AXI_AW-1:0] m;
    m = top - lo;
    ob_xlate = (tr & ~{16'h0000, m}) | {16'h0000, (a - lo) & m};
  endfunction

  // window hit: low bound through last valid byte
  function automatic logic ob_hit(input logic [AXI_AW-1:0] a,
      input logic [AXI_AW-1:0] lo, input logic [AXI_AW-1:0] top);
    ob_hit = (a >= lo) && (a <= top);
  endfunction

  // configuration state
  logic [AXI_AW-1:0]  win_lo_q [NUM_OB], win_lo_d [NUM_OB];   // low bounds
  logic [AXI_AW-1:0]  win_top_q[NUM_OB], win_top_d[NUM_OB];   // top bounds
  logic [PCIE_AW-1:0] win_tr_q [NUM_OB], win_tr_d [NUM_OB];   // translation
  logic [AXI_AW-1:0]  bar_tr_q [NUM_IB], bar_tr_d [NUM_IB];   // inbound translation
  logic [5:0]         bar_sz_q [NUM_IB], bar_sz_d [NUM_IB];   // size code, log2
  logic               bar64_q  [NUM_IB], bar64_d  [NUM_IB];   // 64-bit bar
  logic [31:0]        rdat_q, rdat_d;                         // read data
  logic               rack_q, rack_d;                         // read answered
  logic [15:0]        miss_q, miss_d;                         // miss counter
  logic [2:0]         w_idx;                                  // window index
  logic [2:0]         b_idx;                                  // bar index

  assign w_idx = avs_address[5:3];
  assign b_idx = avs_address[4:2];
  // reads wait one cycle for registered data, writes never wait
  assign avs_waitrequest = avs_read && !rack_q;
  assign avs_readdata    = rdat_q;

  // outbound decode over all six windows
  logic                ob_any;           // some window hit
  logic [PCIE_AW-1:0]  ob_addr;          // translated address
  apt_tlp_t            ob_tlp;           // header to buffer
  always_comb begin
    ob_any  = 1'b0;
    ob_addr = '0;
    for (int i = 0; i < NUM_OB; i++) begin
      if (!ob_any && ob_hit(ob_req_i.addr, win_lo_q[i], win_top_q[i])) begin
        ob_any  = 1'b1;
        ob_addr = ob_xlate(ob_req_i.addr, win_lo_q[i], win_top_q[i], win_tr_q[i]);
      end
    end
    ob_tlp.addr    = ob_addr;
    ob_tlp.write   = ob_req_i.write;
    ob_tlp.four_dw = (ob_addr[63:32] != 32'h0000_0000);
    ob_tlp.len     = ob_req_i.len;
  end

  // transmit buffer
  logic buf_in_ready;   // buffer accepts
  logic tx_wr_done;     // write header leaves toward the link
  logic ob_take;        // outbound request accepted
  apt_buf2 #(.W($bits(apt_tlp_t))) u_txbuf (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (ob_valid_i && ob_any),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (ob_tlp),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i),
    .out_data_o  (tx_tlp_o)
  );
  assign tx_wr_done = tx_valid_o && tx_ready_i && tx_tlp_o.write;
  // a miss waits while a write response goes out
  assign ob_ready_o = ob_any ? buf_in_ready : !tx_wr_done;
  assign ob_take    = ob_valid_i && ob_ready_o;

  // outbound response state
  logic rsp_v_q, rsp_v_d, rsp_e_q, rsp_e_d, rsp_w_q, rsp_w_d;
  always_comb begin
    rsp_v_d = 1'b0;
    rsp_e_d = 1'b0;
    rsp_w_d = 1'b0;
    if (tx_wr_done) begin                     // header is on the link
      rsp_v_d = 1'b1;
      rsp_w_d = 1'b1;
    end else if (ob_take && !ob_any) begin    // outside every window
      rsp_v_d = 1'b1;
      rsp_e_d = 1'b1;
      rsp_w_d = ob_req_i.write;
    end
  end
  assign ob_resp_valid_o = rsp_v_q;
  assign ob_resp_err_o   = rsp_e_q;
  assign ob_resp_write_o = rsp_w_q;

  // inbound stage and outstanding write count
  logic [CNT_W-1:0] wcnt_q, wcnt_d;     // writes awaiting response
  logic             ax_v_q, ax_v_d;     // stage full
  apt_axi_req_t     ax_q, ax_d;         // stage request
  logic             ax_ro_q, ax_ro_d;   // stage relaxed
  logic             ierr_q, ierr_d;     // disabled bar pulse
  logic             ax_go;              // stage may be issued
  logic             ax_fire;            // stage taken by fabric
  logic             ib_bad;             // disabled or absent bar
  logic [PCIE_AW-1:0] ib_mask;          // offset mask of bar
  logic [2:0]       ib_bar;
  logic [2:0]       ib_prev;

  assign ib_bar  = ib_req_i.bar;
  assign ib_prev = ib_bar - 3'h1;
  assign ib_bad  = (ib_bar >= 3'(NUM_IB)) ||
                   ((ib_bar != 3'h0) && bar64_q[ib_prev]);
  assign ib_mask = (64'h0000_0000_0000_0001 << bar_sz_q[ib_bar]) - 64'h0000_0000_0000_0001;
  // strict reads wait until no write is pending
  assign ax_go   = ax_q.write ? (wcnt_q != WR_CNT_MAX)
                 : (ax_ro_q || (wcnt_q == '0));
  assign axi_valid_o = ax_v_q && ax_go;
  assign axi_req_o   = ax_q;
  assign ax_fire     = axi_valid_o && axi_ready_i;
  assign ib_ready_o  = !ax_v_q || ax_fire;
  assign ib_err_o    = ierr_q;

  always_comb begin
    ax_v_d  = ax_v_q;
    ax_d    = ax_q;
    ax_ro_d = ax_ro_q;
    ierr_d  = 1'b0;
    wcnt_d  = wcnt_q;
    if (ax_fire) begin
      ax_v_d = 1'b0;
    end
    if (ib_valid_i && ib_ready_o) begin
      if (ib_bad) begin                       // drop, flag
        ierr_d = 1'b1;
      end else begin
        ax_v_d     = 1'b1;
        ax_d.addr  = AXI_AW'({16'h0000, bar_tr_q[ib_bar]} & ~ib_mask
                             | ib_req_i.addr & ib_mask);
        ax_d.write = ib_req_i.write;
        ax_ro_d    = ib_req_i.relaxed;
      end
    end
    // count issued writes up, returned responses down
    if ((ax_fire && ax_q.write) && !axi_bresp_i) begin
      wcnt_d = wcnt_q + 4'h1;
    end else if (!(ax_fire && ax_q.write) && axi_bresp_i && (wcnt_q != '0)) begin
      wcnt_d = wcnt_q - 4'h1;
    end
  end

  // completion data stage, held behind earlier writes
  logic        rd_v_q, rd_v_d;
  logic [63:0] rd_q, rd_d;
  assign cpl_ready_o = (wcnt_q == '0) && !(ax_v_q && ax_q.write)
                       && (!rd_v_q || rd_ready_i);
  assign rd_valid_o  = rd_v_q;
  assign rd_data_o   = rd_q;
  always_comb begin
    rd_v_d = rd_v_q;
    rd_d   = rd_q;
    if (rd_v_q && rd_ready_i) begin
      rd_v_d = 1'b0;
    end
    if (cpl_valid_i && cpl_ready_o) begin
      rd_v_d = 1'b1;
      rd_d   = cpl_data_i;
    end
  end

  // register file: writes and read data
  always_comb begin
    win_lo_d  = win_lo_q;
    win_top_d = win_top_q;
    win_tr_d  = win_tr_q;
    bar_tr_d  = bar_tr_q;
    bar_sz_d  = bar_sz_q;
    bar64_d   = bar64_q;
    miss_d    = miss_q + 16'(ob_take && !ob_any);
    rack_d    = avs_read && !rack_q;
    rdat_d    = RD_ZERO;                      // unmapped reads as zero
    if (avs_address < IB_BASE && w_idx < 3'(NUM_OB)) begin
      case (avs_address[2:0])
        OB_LO_L: begin
          rdat_d = win_lo_q[w_idx][31:0];
          if (avs_write) win_lo_d[w_idx][31:0] = avs_writedata;
        end
        OB_LO_H: begin
          rdat_d = {16'h0000, win_lo_q[w_idx][47:32]};
          if (avs_write) win_lo_d[w_idx][47:32] = avs_writedata[15:0];
        end
        OB_TOP_L: begin
          rdat_d = win_top_q[w_idx][31:0];
          if (avs_write) win_top_d[w_idx][31:0] = avs_writedata;
        end
        OB_TOP_H: begin
          rdat_d = {16'h0000, win_top_q[w_idx][47:32]};
          if (avs_write) win_top_d[w_idx][47:32] = avs_writedata[15:0];
        end
        OB_TR_L: begin
          rdat_d = win_tr_q[w_idx][31:0];
          if (avs_write) win_tr_d[w_idx][31:0] = avs_writedata;
        end
        OB_TR_H: begin
          rdat_d = win_tr_q[w_idx][63:32];
          if (avs_write) win_tr_d[w_idx][63:32] = avs_writedata;
        end
        default: rdat_d = RD_ZERO;
      endcase
    end else if (avs_address >= IB_BASE && avs_address < STAT_ADDR && b_idx < 3'(NUM_IB)) begin
      case (avs_address[1:0])
        IB_TR_L: begin
          rdat_d = bar_tr_q[b_idx][31:0];
          if (avs_write) bar_tr_d[b_idx][31:0] = avs_writedata;
        end
        IB_TR_H: begin
          rdat_d = {16'h0000, bar_tr_q[b_idx][47:32]};
          if (avs_write) bar_tr_d[b_idx][47:32] = avs_writedata[15:0];
        end
        IB_CFG: begin
          rdat_d = {23'h00_0000, bar64_q[b_idx], 2'h0, bar_sz_q[b_idx]};
          if (avs_write) begin
            bar_sz_d[b_idx] = avs_writedata[5:0];
            bar64_d[b_idx]  = avs_writedata[IB_CFG_64];
          end
        end
        default: rdat_d = RD_ZERO;
      endcase
    end else if (avs_address == STAT_ADDR) begin
      rdat_d = {miss_q, 7'h00, rd_v_q, tx_valid_o, ax_v_q, 2'h0, wcnt_q};
    end
  end

  // all registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_OB; i++) begin
        win_lo_q[i]  <= OB_LO_RST;
        win_top_q[i] <= OB_TOP_RST;
        win_tr_q[i]  <= OB_TR_RST;
      end
      for (int i = 0; i < NUM_IB; i++) begin
        bar_tr_q[i] <= IB_TR_RST;
        bar_sz_q[i] <= IB_SZ_RST;
        bar64_q[i]  <= 1'b0;
      end
      rdat_q  <= RD_ZERO;
      rack_q  <= 1'b0;
      miss_q  <= 16'h0000;
      rsp_v_q <= 1'b0;
      rsp_e_q <= 1'b0;
      rsp_w_q <= 1'b0;
      wcnt_q  <= '0;
      ax_v_q  <= 1'b0;
      ax_q    <= '0;
      ax_ro_q <= 1'b0;
      ierr_q  <= 1'b0;
      rd_v_q  <= 1'b0;
      rd_q    <= 64'h0000_0000_0000_0000;
    end else begin
      win_lo_q  <= win_lo_d;
      win_top_q <= win_top_d;
      win_tr_q  <= win_tr_d;
      bar_tr_q  <= bar_tr_d;
      bar_sz_q  <= bar_sz_d;
      bar64_q   <= bar64_d;
      rdat_q    <= rdat_d;
      rack_q    <= rack_d;
      miss_q    <= miss_d;
      rsp_v_q   <= rsp_v_d;
      rsp_e_q   <= rsp_e_d;
      rsp_w_q   <= rsp_w_d;
      wcnt_q    <= wcnt_d;
      ax_v_q    <= ax_v_d;
      ax_q      <= ax_d;
      ax_ro_q   <= ax_ro_d;
      ierr_q    <= ierr_d;
      rd_v_q    <= rd_v_d;
      rd_q      <= rd_d;
    end
  end

  // checks
  a_bresp_after_tx: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ob_resp_valid_o && !ob_resp_err_o && ob_resp_write_o |-> $past(tx_wr_done))
    else $error("write response without sent header");
  a_strict_read_wait: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    axi_valid_o && !axi_req_o.write && !ax_ro_q |-> wcnt_q == '0)
    else $error("strict read passed pending write");
  a_relaxed_pass: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ax_v_q && ax_ro_q && !ax_q.write |-> axi_valid_o)
    else $error("relaxed read held back");
  a_cpl_after_bresp: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cpl_valid_i && cpl_ready_o |=> rd_valid_o && $past(wcnt_q) == '0)
    else $error("completion passed pending write");
  a_miss_slverr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ob_valid_i && ob_ready_o && !ob_any |=> ob_resp_valid_o && ob_resp_err_o)
    else $error("miss without error response");
  a_tlp_format: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    tx_valid_o |-> tx_tlp_o.four_dw == (tx_tlp_o.addr[63:32] != 32'h0000_0000))
    else $error("header size does not match address");
  a_bar_disabled: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ib_valid_i && ib_ready_o && ib_bad |=> ib_err_o && !ax_v_q)
    else $error("disabled bar not flagged");
  a_offset_kept: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ob_valid_i && ob_ready_o && ob_any |-> ob_addr[11:0] == 12'(ob_req_i.addr - win_lo_q[0]) ||
    !ob_hit(ob_req_i.addr, win_lo_q[0], win_top_q[0]))
    else $error("window offset not kept");
endmodule

/* File: design/apt_pkg.sv */
package apt_pkg;
  localparam int AXI_AW    = 48;              // axi address width
  localparam int PCIE_AW   = 64;              // link address width
  localparam int DATA_W    = 64;              // completion data width
  localparam int NUM_OB    = 6;               // outbound_window_count
  localparam int NUM_IB    = 6;               // inbound_window_count
  localparam int CNT_W     = 4;               // outstanding write counter width
  localparam logic [CNT_W-1:0] WR_CNT_MAX = 4'hF;
  // register map, word indices
  localparam logic [7:0] OB_BASE   = 8'h00;   // window w at OB_BASE + 8*w
  localparam logic [7:0] IB_BASE   = 8'h40;   // bar b at IB_BASE + 4*b
  localparam logic [7:0] STAT_ADDR = 8'h60;   // status word
  localparam logic [2:0] OB_LO_L = 3'h0, OB_LO_H = 3'h1, OB_TOP_L = 3'h2;
  localparam logic [2:0] OB_TOP_H = 3'h3, OB_TR_L = 3'h4, OB_TR_H = 3'h5;
  localparam logic [1:0] IB_TR_L = 2'h0, IB_TR_H = 2'h1, IB_CFG = 2'h2;
  localparam int IB_CFG_64 = 8;               // cfg bit: bar is 64-bit
  // reset values: empty windows never hit
  localparam logic [AXI_AW-1:0]  OB_LO_RST  = 48'hFFFF_FFFF_FFFF;
  localparam logic [AXI_AW-1:0]  OB_TOP_RST = 48'h0000_0000_0000;
  localparam logic [PCIE_AW-1:0] OB_TR_RST  = 64'h0000_0000_0000_0000;
  localparam logic [AXI_AW-1:0]  IB_TR_RST  = 48'h0000_0000_0000;
  localparam logic [5:0]         IB_SZ_RST  = 6'h0C;  // 4 KB
  localparam logic [31:0]        RD_ZERO    = 32'h0000_0000;

  typedef struct packed {
    logic [AXI_AW-1:0] addr;    // axi address
    logic              write;   // 1 write, 0 read
    logic [7:0]        len;     // burst length
  } apt_ob_req_t;

  typedef struct packed {
    logic [PCIE_AW-1:0] addr;   // translated link address
    logic               write;  // memory write, else read
    logic               four_dw; // 4DW header
    logic [7:0]         len;
  } apt_tlp_t;

  typedef struct packed {
    logic [PCIE_AW-1:0] addr;   // link address of request
    logic [2:0]         bar;    // bar that was hit
    logic               write;
    logic               relaxed; // relaxed ordering attribute
  } apt_ib_req_t;

  typedef struct packed {
    logic [AXI_AW-1:0] addr;
    logic              write;
  } apt_axi_req_t;
endpackage

/* File: design/apt_buf2.sv */
`timescale 1ns/1ps
// two-entry buffer, full throughput, no word lost on stall
module apt_buf2 #(
  parameter int W = 8
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  logic [W-1:0] mem_q [2];       // storage
  logic [W-1:0] mem_d [2];
  logic         wp_q, wp_d;      // write index
  logic         rp_q, rp_d;      // read index
  logic [1:0]   cnt_q, cnt_d;    // fill level
  logic         push, pop;

  // handshakes from honest full and empty
  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // next state
  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data_i;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

/* File: tb/apt_partner.sv */
`timescale 1ns/1ps
// fabric slave and link sink on the far side of the bridge
module apt_partner (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  axi_valid_i,
  input  wire apt_pkg::apt_axi_req_t axi_req_i,
  input  wire logic                  hold_i,
  input  wire logic                  stall_i,
  output logic                       axi_ready_o,
  output logic                       axi_bresp_o,
  output logic                       tx_ready_o
);
  import apt_pkg::*;
  logic [4:0] pend_q;  // writes taken, response owed
  logic [4:0] pend_d;
  logic       resp_d;
  // prompt or slow acceptance, as the bench stalls
  assign axi_ready_o = !stall_i;
  assign tx_ready_o  = !stall_i;
  // one response pulse at a time, never while held
  always_comb begin
    pend_d = pend_q + 5'(axi_valid_i && axi_ready_o && axi_req_i.write);
    resp_d = !hold_i && (pend_d != 5'h0) && !axi_bresp_o;
    if (resp_d) begin
      pend_d = pend_d - 5'h1;
    end
  end
  // register owed count and response pulse
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q      <= 5'h0;
      axi_bresp_o <= 1'b0;
    end else begin
      pend_q      <= pend_d;
      axi_bresp_o <= resp_d;
    end
  end
endmodule

/* File: tb/apt_bridge_tb_top.sv */
`timescale 1ns/1ps
module apt_bridge_tb_top;
  import apt_pkg::*;
  logic          core_clk_i, rst_n_i, avs_read, avs_write, avs_waitrequest;
  logic [7:0]    avs_address;
  logic [31:0]   avs_writedata, avs_readdata, d;
  logic          ob_valid_i, ob_ready_o, ob_resp_valid_o, ob_resp_err_o, ob_resp_write_o, tx_valid_o, tx_ready_i;
  apt_ob_req_t   ob_req_i;
  apt_tlp_t      tx_tlp_o;
  logic          ib_valid_i, ib_ready_o, ib_err_o, axi_valid_o, axi_ready_i, axi_bresp_i;
  apt_ib_req_t   ib_req_i;
  apt_axi_req_t  axi_req_o;
  logic          cpl_valid_i, cpl_ready_o, rd_valid_o, rd_ready_i, hold, stall;
  logic [63:0]   cpl_data_i, rd_data_o, a;
  logic [47:0]   e;
  logic [2:0]    got;
  int            seed = 34, fails = 0, comparisons = 0, n;
  // window table: low, top, translation
  logic [47:0] lo[6] = '{48'h0000_1234_0000, 48'h0000_ABCD_E000, 48'h0000_FE00_0000, 48'h0000_0000_0000,
                         48'h0100_0000_0000, 48'h8000_0000_F000};
  logic [47:0] top[6] = '{48'h0000_1234_FFFF, 48'h0000_ABCD_FFFF, 48'h0000_FFFF_FFFF, 48'h0000_0000_0FFF,
                          48'h0100_0000_FFFF, 48'h8000_0000_FFFF};
  logic [63:0] tr[6] = '{64'h0000_0000_5671_0000, 64'h5000_0000_FEDC_0000, 64'h0000_0000_4000_0000,
                         64'h6000_0000_8765_4000, 64'h0000_0001_0000_0000, 64'h0000_0000_0000_1000};

  apt_bridge apt_bridge_inst (.core_clk_i, .rst_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .ob_valid_i, .ob_ready_o, .ob_req_i, .ob_resp_valid_o, .ob_resp_err_o,
    .ob_resp_write_o, .tx_valid_o, .tx_ready_i, .tx_tlp_o, .ib_valid_i, .ib_ready_o, .ib_req_i, .ib_err_o,
    .axi_valid_o, .axi_ready_i, .axi_req_o, .axi_bresp_i, .cpl_valid_i, .cpl_ready_o, .cpl_data_i,
    .rd_valid_o, .rd_ready_i, .rd_data_o);
  apt_partner apt_partner_inst (.core_clk_i, .rst_n_i, .axi_valid_i(axi_valid_o), .axi_req_i(axi_req_o),
    .hold_i(hold), .stall_i(stall), .axi_ready_o(axi_ready_i), .axi_bresp_o(axi_bresp_i), .tx_ready_o(tx_ready_i));

  // clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // random stall of link and fabric, about one cycle in four
  always @(posedge core_clk_i) stall <= ($random(seed) & 3) == 0;

  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [63:0] s, input logic [63:0] x);
    comparisons++;
    if (s !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  // one edge, with a bound on every wait
  task automatic tick(inout int c);
    @(posedge core_clk_i);
    c++;
    if (c > 200) begin
      fails++;
      $display("ERROR wait expected handshake seen none");
      close_out();
    end
  endtask
  task automatic avs_wr(input logic [7:0] ad, input logic [31:0] wd);
    int c = 0;
    @(posedge core_clk_i);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_write <= 1'b1;
    do tick(c); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic avs_rd(input logic [7:0] ad, output logic [31:0] rd);
    int c = 0;
    @(posedge core_clk_i);
    avs_address <= ad;
    avs_read <= 1'b1;
    do tick(c); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask
  function automatic logic [63:0] ob_x(logic [47:0] ad, int w);
    logic [63:0] m;
    m = 64'(top[w] - lo[w]);
    return (tr[w] & ~m) | (64'(ad - lo[w]) & m);
  endfunction
  // outbound request, then header or error response
  task automatic ob_go(input logic [47:0] ad, input logic w, input logic hit, input logic [63:0] x);
    int c = 0;
    @(posedge core_clk_i);
    ob_req_i <= '{ad, w, 8'h03};
    ob_valid_i <= 1'b1;
    do tick(c); while (ob_ready_o !== 1'b1);
    ob_valid_i <= 1'b0;
    if (hit) begin
      do begin
        tick(c);
        check("early_resp", ob_resp_valid_o, 1'b0);
      end while (!(tx_valid_o === 1'b1 && tx_ready_i === 1'b1));
      check("tx_addr", tx_tlp_o.addr, x);
      check("tx_hdr", {tx_tlp_o.four_dw, tx_tlp_o.write, tx_tlp_o.len}, {|x[63:32], w, 8'h03});
      if (w) begin
        tick(c);
        check("wr_resp", {ob_resp_valid_o, ob_resp_err_o, ob_resp_write_o}, 3'b101);
      end
    end else begin
      tick(c);
      check("miss_resp", {ob_resp_valid_o, ob_resp_err_o, ob_resp_write_o, tx_valid_o}, {2'b11, w, 1'b0});
    end
  endtask
  task automatic ib_go(input apt_ib_req_t r);
    int c = 0;
    @(posedge core_clk_i);
    ib_req_i <= r;
    ib_valid_i <= 1'b1;
    do tick(c); while (ib_ready_o !== 1'b1);
    ib_valid_i <= 1'b0;
  endtask
  task automatic ax_wait(input logic [47:0] x, input logic w);
    int c = 0;
    do tick(c); while (!(axi_valid_o === 1'b1 && axi_ready_i === 1'b1));
    check("axi_req", {axi_req_o.addr, axi_req_o.write}, {x, w});
  endtask

  initial begin
    {avs_read, avs_write, ob_valid_i, ib_valid_i, cpl_valid_i, hold, stall} = '0;
    {avs_address, avs_writedata, ob_req_i, ib_req_i, cpl_data_i} = '0;
    rd_ready_i = 1'b1;
    rst_n_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    // reset values, unmapped read, empty windows miss
    avs_rd(8'h00, d);
    check("lo_l_rst", d, 32'hFFFF_FFFF);
    avs_rd(8'h01, d);
    check("lo_h_rst", d, 32'h0000_FFFF);
    avs_rd(8'h42, d);
    check("bar_cfg_rst", d, 32'h0000_000C);
    avs_rd(8'h7F, d);
    check("unmapped", d, 32'h0000_0000);
    ob_go(lo[0], 1'b1, 1'b0, 64'h0);
    $display("test reset done");
    // power-of-two windows, translation low bits zero
    for (int w = 0; w < 6; w++) begin
      for (int k = 0; k < 6; k++) begin
        a = k[1] ? {16'h0, top[w]} : k[2] ? tr[w] : {16'h0, lo[w]};
        avs_wr(8'(8 * w + k), k[0] ? (k[2] ? a[63:32] : {16'h0, a[47:32]}) : a[31:0]);
      end
    end
    avs_rd(8'h2B, d);
    check("top_h_rd", d, 32'h0000_8000);
    // two points worked out by hand, then low, top and a random point of each window against ob_x, then two misses
    ob_go(48'h0000_1234_0ABC, 1'b1, 1'b1, 64'h0000_0000_5671_0ABC);
    ob_go(48'h0000_ABCD_F123, 1'b0, 1'b1, 64'h5000_0000_FEDC_1123);
    for (int w = 0; w < 6; w++) begin
      for (int k = 0; k < 3; k++) begin
        e = (k == 0) ? lo[w] : (k == 1) ? top[w] : lo[w] + (48'($random(seed)) & (top[w] - lo[w]));
        ob_go(e, 1'($random(seed)), 1'b1, ob_x(e, w));
      end
    end
    ob_go(top[0] + 48'h1, 1'b1, 1'b0, 64'h0);
    ob_go(48'h7000_0000_0000, 1'b0, 1'b0, 64'h0);
    $display("test outbound done");
    // bar0 64-bit 32K, bar2 32-bit 32M
    hold <= 1'b1;
    avs_wr(8'h40, 32'h1234_0000);
    avs_wr(8'h42, 32'h0000_010F);
    avs_wr(8'h48, 32'hFE00_0000);
    avs_wr(8'h4A, 32'h0000_0019);
    for (int i = 0; i < 3; i++) begin
      ib_go('{64'h0, 3'(i == 0 ? 1 : 5 + i), 1'b0, 1'b0});
      tick(n);
      check("bad_bar", ib_err_o, 1'b1);
    end
    ib_go('{64'h2000_0000_ABCD_FFF4, 3'd0, 1'b1, 1'b0});
    ax_wait(48'h0000_1234_7FF4, 1'b1);
    a = {32'hA000_0001, $random(seed)};
    ib_go('{a, 3'd2, 1'b0, 1'b1});
    ax_wait({16'h0, 7'h7F, a[24:0]}, 1'b0);
    a = {32'hA000_0001, $random(seed)};
    ib_go('{a, 3'd2, 1'b0, 1'b0});
    cpl_data_i <= {$random(seed), $random(seed)};
    cpl_valid_i <= 1'b1;
    n = 0;
    repeat (12) begin
      tick(n);
      check("held", {axi_valid_o, cpl_ready_o, rd_valid_o}, 3'b000);
    end
    hold <= 1'b0;
    got = 3'b000;
    n = 0;
    do begin
      tick(n);
      if (axi_valid_o === 1'b1 && axi_ready_i === 1'b1) begin
        check("strict_rd", axi_req_o, {16'h0, 7'h7F, a[24:0], 1'b0});
        got[0] = 1'b1;
      end
      if (cpl_valid_i === 1'b1 && cpl_ready_o === 1'b1) begin
        cpl_valid_i <= 1'b0;
        got[1] = 1'b1;
      end
      if (rd_valid_o === 1'b1) begin
        check("rd_data", rd_data_o, cpl_data_i);
        got[2] = 1'b1;
      end
    end while (got != 3'b111);
    $display("test inbound done");
    close_out();
  end
endmodule
